// ### dv/digital_input_scan_filter_tb_top.sv
// self-checking bench for the binary input scanner
// assumes shortened cycle and millisecond counts
`timescale 1ns/1ps
module digital_input_scan_filter_tb_top;
	import dinscan_pkg::*;
	localparam int CT  = 50;
	localparam int MT  = 10;
	localparam int NCH = BASE_INPUTS + ADDON_INPUTS;
	logic                          clock, reset, clock_enable, scan_tick;
	avmm_req_t                     bus_req;
	avmm_rsp_t                     bus_rsp;
	logic [BASE_INPUTS-1:0]        base_pins;
	logic [ADDON_INPUTS*VOLT_W-1:0] addon_volts;
	logic [NCH-1:0]                filtered_state, logic_state, energize, ev;
	logic [CONTACTS-1:0]           contacts;
	logic [ADDON_INPUTS-1:0]       mid;
	logic [31:0]                   q, pol, route, count0;
	int                            fails, total_checks, cycles;
	logic [7:0]  reg_addr [7] = '{REG_POLARITY, REG_AC_MODE, REG_ROUTE, REG_NUMBERING,
		REG_DROP_DELAY + 8'h28, REG_THRESH + 8'h1C, 8'h20};
	logic [31:0] reg_exp [7] = '{32'h0, 32'h0, ROUTE_RESET, 32'(PRECEDING_INPUTS + 1),
		32'(DELAY_RESET), {16'h0, REL_THRESH_RESET, ACT_THRESH_RESET}, 32'h0};

	dinscan_top #(.CYCLE_TICKS(CT), .MS_TICKS(MT)) dut (
		.clock(clock), .reset(reset), .clock_enable(clock_enable), .bus_req(bus_req),
		.bus_rsp(bus_rsp), .base_pins(base_pins), .addon_volts(addon_volts),
		.filtered_state(filtered_state), .logic_state(logic_state),
		.output_contact_channels(contacts), .scan_tick(scan_tick));
	dinscan_field field (.energize(energize), .mid(mid), .base_pins(base_pins), .addon_volts(addon_volts));

	// ==========================================================
	// helpers
	task automatic close_out();
		if (fails == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : close_out
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", what, exp, got);
			fails++;
		end
	endtask : chk
	// request held until waitrequest is sampled low at a rising edge; data taken there
	task automatic bus_acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		bus_req <= '{address: a, read: ~wr, write: wr, writedata: d};
		do @(posedge clock); while (bus_rsp.waitrequest !== 1'b0);
		q = bus_rsp.readdata;
		bus_req <= '0;
	endtask : bus_acc
	task automatic wait_ticks(input int n);
		repeat (n) begin
			do @(negedge clock); while (scan_tick !== 1'b1);
		end
		repeat (3) @(negedge clock);
	endtask : wait_ticks
	function automatic logic [31:0] route_out(input logic [NCH-1:0] s, input logic [31:0] r);
		logic [31:0] c;
		c = '0;
		for (int k = 0; k < CONTACTS; k++) c[k] = s[r[4*k +: 4]];
		return c;
	endfunction : route_out

	// ==========================================================
	// clock, timeout
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			close_out();
		end
	end

	// ==========================================================
	// main sequence
	initial begin
		reset = 1'b1;
		clock_enable = 1'b1;
		bus_req = '0;
		energize = '0;
		mid = '0;
		void'($urandom(32'hDCD145B1));
		repeat (10) @(posedge clock);
		reset <= 1'b0;
		foreach (reg_addr[i]) begin
			bus_acc(1'b0, reg_addr[i], 32'h0);
			chk("reset value", reg_exp[i], q);
		end
		bus_acc(1'b1, REG_ACT_DELAY + 8'h04, 32'h001E_8480);
		bus_acc(1'b0, REG_ACT_DELAY + 8'h04, 32'h0);
		chk("delay clip", 32'(MAX_DELAY_MS), q);
		bus_acc(1'b1, REG_ACT_DELAY + 8'h04, 32'h0);
		bus_acc(1'b1, REG_FILTERED, 32'h7FF);
		bus_acc(1'b0, REG_FILTERED, 32'h0);
		chk("read-only filtered", 32'h0, q);
		for (int i = 0; i < 8; i++) begin
			pol = (i == 0) ? 32'h7FF : $urandom & 32'h7FF;
			ev = (i == 0) ? '1 : NCH'($urandom);
			route = '0;
			for (int k = 0; k < CONTACTS; k++) route[4*k +: 4] = 4'($urandom % NCH);
			bus_acc(1'b1, REG_POLARITY, pol);
			bus_acc(1'b1, REG_ROUTE, route);
			bus_acc(1'b0, REG_POLARITY, 32'h0);
			chk("polarity", pol, q);
			@(posedge clock) energize <= ev;
			wait_ticks(2);
			chk("filtered", 32'(ev ^ pol[NCH-1:0]), 32'(filtered_state));
			bus_acc(1'b0, REG_FILTERED, 32'h0);
			chk("filtered reg", 32'(ev ^ pol[NCH-1:0]), q);
			wait_ticks(1);
			chk("logic", 32'(ev ^ pol[NCH-1:0]), 32'(logic_state));
			wait_ticks(1);
			chk("contacts", route_out(ev ^ pol[NCH-1:0], route), 32'(contacts));
		end
		// pulse shorter than the delay, then a full one
		@(posedge clock) energize <= '0;
		bus_acc(1'b1, REG_POLARITY, 32'h0);
		bus_acc(1'b1, REG_ACT_DELAY + 8'h0C, 32'h14);
		bus_acc(1'b1, REG_DROP_DELAY + 8'h0C, 32'h14);
		bus_acc(1'b1, REG_AC_MODE, 32'h8);
		wait_ticks(3);
		@(posedge clock) energize[3] <= 1'b1;
		wait_ticks(3);
		chk("act delay hold", 32'h0, 32'(filtered_state[3]));
		@(posedge clock) energize[3] <= 1'b0;
		wait_ticks(1);
		@(posedge clock) energize[3] <= 1'b1;
		wait_ticks(2);
		chk("pending dropped", 32'h0, 32'(filtered_state[3]));
		wait_ticks(4);
		chk("act delay done", 32'h1, 32'(filtered_state[3]));
		@(posedge clock) energize[3] <= 1'b0;
		wait_ticks(8);
		chk("drop with ac hold", 32'h1, 32'(filtered_state[3]));
		wait_ticks(4);
		chk("drop done", 32'h0, 32'(filtered_state[3]));
		bus_acc(1'b1, REG_THRESH + 8'h04, 32'h2840);
		@(posedge clock) mid <= 8'h06;
		wait_ticks(2);
		chk("thresholds", 32'h1, 32'(filtered_state[5:4]));
		// freeze well clear of a tick: 120 frozen clocks would hold at least two ticks if enable leaked
		bus_acc(1'b0, REG_SCAN_COUNT, 32'h0);
		count0 = q;
		@(posedge clock) clock_enable <= 1'b0;
		repeat (120) @(posedge clock);
		clock_enable <= 1'b1;
		bus_acc(1'b0, REG_SCAN_COUNT, 32'h0);
		chk("scan count frozen", 32'h1, 32'((q - count0) <= 32'h1));
		close_out();
	end
endmodule : digital_input_scan_filter_tb_top

// ### dv/dinscan_asserts.sv
// concurrent checks on the scanner top-level ports
// assumes clock_enable only drops while scan_tick and the bus are idle
`timescale 1ns/1ps
module dinscan_asserts
	import dinscan_pkg::*;
#(
	parameter int BASE_N      = BASE_INPUTS,
	parameter int ADDON_N     = ADDON_INPUTS,
	parameter int PRECEDING_N = PRECEDING_INPUTS,
	parameter int CONTACT_N   = CONTACTS,
	parameter int CYCLE_TICKS = CYCLE_CLOCKS
) (
	input wire logic                      clock,
	input wire logic                      reset,
	input wire logic                      clock_enable,
	input wire avmm_req_t                 bus_req,
	input wire avmm_rsp_t                 bus_rsp,
	input wire logic [BASE_N-1:0]         base_pins,
	input wire logic [ADDON_N*VOLT_W-1:0] addon_volts,
	input wire logic [BASE_N+ADDON_N-1:0] filtered_state,
	input wire logic [BASE_N+ADDON_N-1:0] logic_state,
	input wire logic [CONTACT_N-1:0]      output_contact_channels,
	input wire logic                      scan_tick
);
	// ==========================================================
	// tick spacing helper
	int unsigned gap;
	logic        seen;
	always_ff @(posedge clock) begin
		if (reset) begin
			gap  <= 0;
			seen <= 1'b0;
		end else if (scan_tick) begin
			gap  <= 0;
			seen <= 1'b1;
		end else if (clock_enable) begin
			gap <= gap + 1;
		end
	end

	// ==========================================================
	// properties
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	sequence s_req_wait;
		(bus_req.read || bus_req.write) && bus_rsp.waitrequest;
	endsequence
	sequence s_req_done;
		(bus_req.read || bus_req.write) && !bus_rsp.waitrequest;
	endsequence
	sequence s_rd(logic [7:0] a);
		bus_req.read && bus_req.address == a && !bus_rsp.waitrequest;
	endsequence
	property p_tick_gap;
		scan_tick && seen |-> gap == CYCLE_TICKS - 1 ##1 !scan_tick;
	endproperty
	property p_logic_take;
		scan_tick |=> logic_state == $past(filtered_state);
	endproperty
	property p_logic_hold;
		!scan_tick |=> $stable(logic_state);
	endproperty
	property p_contact_hold;
		!scan_tick |=> $stable(output_contact_channels);
	endproperty
	property p_one_wait;
		s_req_wait |=> s_req_done;
	endproperty
	property p_idle;
		!(bus_req.read || bus_req.write) |-> !bus_rsp.waitrequest;
	endproperty
	property p_numbering;
		s_rd(REG_NUMBERING) |-> bus_rsp.readdata == 32'(PRECEDING_N + 1);
	endproperty
	property p_filtered_read;
		s_rd(REG_FILTERED) |-> bus_rsp.readdata[BASE_N+ADDON_N-1:0] == $past(filtered_state);
	endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("scan tick spacing wrong");
	a_logic_take: assert property (p_logic_take) else $error("logic stage missed tick");
	a_logic_hold: assert property (p_logic_hold) else $error("logic stage moved off tick");
	a_contact_hold: assert property (p_contact_hold) else $error("contacts moved off tick");
	a_one_wait: assert property (p_one_wait) else $error("bus wait not one cycle");
	a_idle: assert property (p_idle) else $error("waitrequest high while idle");
	a_numbering: assert property (p_numbering) else $error("add-on numbering wrong");
	a_filtered_read: assert property (p_filtered_read) else $error("filtered readback wrong");
endmodule : dinscan_asserts

bind dinscan_top dinscan_asserts #(
	.BASE_N(BASE_N), .ADDON_N(ADDON_N), .PRECEDING_N(PRECEDING_N),
	.CONTACT_N(CONTACT_N), .CYCLE_TICKS(CYCLE_TICKS)
) u_chk (
	.clock(clock), .reset(reset), .clock_enable(clock_enable), .bus_req(bus_req),
	.bus_rsp(bus_rsp), .base_pins(base_pins), .addon_volts(addon_volts),
	.filtered_state(filtered_state), .logic_state(logic_state),
	.output_contact_channels(output_contact_channels), .scan_tick(scan_tick)
);

// ### dv/dinscan_field.sv
// field wiring model: base pins and add-on channel voltages
// assumes energize and mid change just after a clock edge
`timescale 1ns/1ps
module dinscan_field
	import dinscan_pkg::*;
(
	input  wire logic [BASE_INPUTS+ADDON_INPUTS-1:0] energize,
	input  wire logic [ADDON_INPUTS-1:0]             mid,
	output logic      [BASE_INPUTS-1:0]              base_pins,
	output logic      [ADDON_INPUTS*VOLT_W-1:0]      addon_volts
);
	// ==========================================================
	// drive
	always_comb begin
		base_pins = energize[BASE_INPUTS-1:0];
		for (int a = 0; a < ADDON_INPUTS; a++) begin
			// mid level sits between default release and activation
			addon_volts[a*VOLT_W +: VOLT_W] = mid[a] ? 8'h46 : energize[BASE_INPUTS+a] ? 8'hC8 : 8'h05;
		end
	end
endmodule : dinscan_field

// ### rtl/dinscan_channel.sv
// pick-up and drop-off delay filter for one channel
// assumes a one-cycle millisecond tick from the scanner
`timescale 1ns/1ps
module dinscan_channel
	import dinscan_pkg::*;
(
	input  wire logic               clock,
	input  wire logic               reset,
	input  wire logic               clock_enable,
	input  wire logic               ms_tick,
	input  wire logic               sample,
	input  wire logic [DELAY_W-1:0] act_delay,
	input  wire logic [DELAY_W-1:0] drop_delay,
	input  wire logic               ac_mode,
	output logic                    state
);

	logic [DELAY_W:0] elapsed;
	logic [DELAY_W:0] limit;

	always_comb begin
		if (sample)
			limit = {1'b0, act_delay};
		else if (ac_mode)
			limit = {1'b0, drop_delay} + (DELAY_W+1)'(AC_HOLD_MS);
		else
			limit = {1'b0, drop_delay};
	end

	// zero delay passes at once; otherwise whole ms ticks are counted
	always_ff @(posedge clock) begin
		if (reset) begin
			state   <= 1'b0;
			elapsed <= '0;
		end else if (clock_enable) begin
			if (sample == state) begin
				elapsed <= '0;
			end else if (elapsed >= limit) begin
				state   <= sample;
				elapsed <= '0;
			end else if (ms_tick) begin
				elapsed <= elapsed + 1'b1;
			end
		end
	end

endmodule : dinscan_channel

// ### rtl/dinscan_sync.sv
// two-stage synchroniser for pins and converter words
// assumes inputs come from outside the clock domain
`timescale 1ns/1ps
module dinscan_sync
	import dinscan_pkg::*;
#(
	parameter int WIDTH = 1
) (
	input  wire logic             clock,
	input  wire logic             reset,
	input  wire logic             clock_enable,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] first_stage;

	// first stage feeds only the second
	always_ff @(posedge clock) begin
		if (reset) begin
			first_stage <= '0;
			sync_out    <= '0;
		end else if (clock_enable) begin
			first_stage <= async_in;
			sync_out    <= first_stage;
		end
	end

endmodule : dinscan_sync

// ### rtl/dinscan_top.sv
// binary input scanner: base pins and add-on voltage channels
// assumes an Avalon-MM master on bus_req and converter words that are slow next to the clock
`timescale 1ns/1ps
module dinscan_top
	import dinscan_pkg::*;
#(
	parameter int BASE_N       = BASE_INPUTS,
	parameter int ADDON_N      = ADDON_INPUTS,
	parameter int PRECEDING_N  = PRECEDING_INPUTS,
	parameter int CONTACT_N    = CONTACTS,
	parameter int CYCLE_TICKS  = CYCLE_CLOCKS,
	parameter int MS_TICKS     = MS_CLOCKS
) (
	input  wire logic                        clock,
	input  wire logic                        reset,
	input  wire logic                        clock_enable,
	input  wire avmm_req_t                   bus_req,
	output avmm_rsp_t                        bus_rsp,
	input  wire logic [BASE_N-1:0]           base_pins,
	input  wire logic [ADDON_N*VOLT_W-1:0]   addon_volts,
	output logic [BASE_N+ADDON_N-1:0]        filtered_state,
	output logic [BASE_N+ADDON_N-1:0]        logic_state,
	output logic [CONTACT_N-1:0]             output_contact_channels,
	output logic                             scan_tick
);

	localparam int CH_N = BASE_N + ADDON_N;

	// ==========================================================
	// settings
	logic [CH_N-1:0]           polarity;
	logic [CH_N-1:0]           ac_mode;
	logic [DELAY_W-1:0]        act_delay  [CH_N];
	logic [DELAY_W-1:0]        drop_delay [CH_N];
	logic [VOLT_W-1:0]         act_thresh [ADDON_N];
	logic [VOLT_W-1:0]         rel_thresh [ADDON_N];
	logic [CONTACT_N*ROUTE_W-1:0] route;

	// ==========================================================
	// pacing
	logic [31:0]               cycle_count;
	logic [31:0]               ms_count;
	logic                      ms_tick;
	logic [31:0]               scan_count;

	// ==========================================================
	// channel path
	logic [BASE_N-1:0]         base_sync;
	logic [ADDON_N*VOLT_W-1:0] volts_sync;
	logic [ADDON_N-1:0]        energized_addon;
	logic [CH_N-1:0]           energized;
	logic [CH_N-1:0]           reported;
	logic [CH_N-1:0]           sampled;

	// ==========================================================
	// bus
	logic                      ack;
	logic [31:0]               readdata;
	logic [5:0]                word;
	logic [1:0]                bank;
	logic [3:0]                index;
	logic                      access;
	logic [DELAY_W-1:0]        delay_value;

	assign access    = (bus_req.read | bus_req.write) & ~ack;
	assign word      = bus_req.address[7:2];
	assign bank      = bus_req.address[7:6];
	assign index     = bus_req.address[5:2];

	// writes above the longest delay clip to it
	assign delay_value = (bus_req.writedata > 32'(MAX_DELAY_MS)) ? DELAY_W'(MAX_DELAY_MS)
	                                                          : bus_req.writedata[DELAY_W-1:0];

	assign bus_rsp.waitrequest = (bus_req.read | bus_req.write) & ~ack;
	assign bus_rsp.readdata    = readdata;

	// ==========================================================
	// program cycle and millisecond ticks
	always_ff @(posedge clock) begin
		if (reset) begin
			cycle_count <= '0;
			scan_tick   <= 1'b0;
		end else if (clock_enable) begin
			if (cycle_count >= 32'(CYCLE_TICKS - 1)) begin
				cycle_count <= '0;
				scan_tick   <= 1'b1;
			end else begin
				cycle_count <= cycle_count + 1'b1;
				scan_tick   <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			ms_count <= '0;
			ms_tick  <= 1'b0;
		end else if (clock_enable) begin
			if (ms_count >= 32'(MS_TICKS - 1)) begin
				ms_count <= '0;
				ms_tick  <= 1'b1;
			end else begin
				ms_count <= ms_count + 1'b1;
				ms_tick  <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset)
			scan_count <= '0;
		else if (clock_enable && scan_tick)
			scan_count <= scan_count + 1'b1;
	end

	// ==========================================================
	// input synchronisers
	dinscan_sync #(
		.WIDTH (BASE_N)
	) base_sync_stage (
		.clock        (clock),
		.reset        (reset),
		.clock_enable (clock_enable),
		.async_in     (base_pins),
		.sync_out     (base_sync)
	);

	// converter words may tear across a change; hysteresis rides it out
	dinscan_sync #(
		.WIDTH (ADDON_N*VOLT_W)
	) volts_sync_stage (
		.clock        (clock),
		.reset        (reset),
		.clock_enable (clock_enable),
		.async_in     (addon_volts),
		.sync_out     (volts_sync)
	);

	// ==========================================================
	// add-on thresholds with hysteresis
	genvar a;
	generate
		for (a = 0; a < ADDON_N; a++) begin : g_addon
			logic [VOLT_W-1:0] volts;
			assign volts = volts_sync[a*VOLT_W +: VOLT_W];

			always_ff @(posedge clock) begin
				if (reset) begin
					energized_addon[a] <= 1'b0;
				end else if (clock_enable) begin
					if (volts > act_thresh[a])
						energized_addon[a] <= 1'b1;
					else if (volts < rel_thresh[a])
						energized_addon[a] <= 1'b0;
				end
			end
		end
	endgenerate

	// add-on channels follow the base ones in numbering
	assign energized = {energized_addon, base_sync};
	assign reported  = energized ^ polarity;

	// ==========================================================
	// per-cycle sampling and delay filters
	always_ff @(posedge clock) begin
		if (reset)
			sampled <= '0;
		else if (clock_enable && scan_tick)
			sampled <= reported;
	end

	genvar c;
	generate
		for (c = 0; c < CH_N; c++) begin : g_chan
			dinscan_channel filter (
				.clock        (clock),
				.reset        (reset),
				.clock_enable (clock_enable),
				.ms_tick      (ms_tick),
				.sample       (sampled[c]),
				.act_delay    (act_delay[c]),
				.drop_delay   (drop_delay[c]),
				.ac_mode      (ac_mode[c]),
				.state        (filtered_state[c])
			);
		end
	endgenerate

	// ==========================================================
	// logic stage and output contacts
	always_ff @(posedge clock) begin
		if (reset)
			logic_state <= '0;
		else if (clock_enable && scan_tick)
			logic_state <= filtered_state;
	end

	genvar k;
	generate
		for (k = 0; k < CONTACT_N; k++) begin : g_contact
			logic [ROUTE_W-1:0] source;
			assign source = route[k*ROUTE_W +: ROUTE_W];

			// sources beyond the channel count leave the contact open
			always_ff @(posedge clock) begin
				if (reset)
					output_contact_channels[k] <= 1'b0;
				else if (clock_enable && scan_tick)
					output_contact_channels[k] <= (32'(source) < CH_N) ? logic_state[source] : 1'b0;
			end
		end
	endgenerate

	// ==========================================================
	// register writes, only at the edge that ends the wait
	always_ff @(posedge clock) begin
		if (reset) begin
			polarity <= '0;
			ac_mode  <= '0;
			route    <= ROUTE_RESET[CONTACT_N*ROUTE_W-1:0];
		end else if (clock_enable && ack && bus_req.write) begin
			case (bus_req.address)
				REG_POLARITY: polarity <= bus_req.writedata[CH_N-1:0];
				REG_AC_MODE:  ac_mode  <= bus_req.writedata[CH_N-1:0];
				REG_ROUTE:    route    <= bus_req.writedata[CONTACT_N*ROUTE_W-1:0];
				default:      ;
			endcase
		end
	end

	genvar d;
	generate
		for (d = 0; d < CH_N; d++) begin : g_delay
			always_ff @(posedge clock) begin
				if (reset) begin
					act_delay[d]  <= DELAY_RESET;
					drop_delay[d] <= DELAY_RESET;
				end else if (clock_enable && ack && bus_req.write && 32'(index) == d) begin
					if (bank == BANK_ACT)
						act_delay[d] <= delay_value;
					else if (bank == BANK_DROP)
						drop_delay[d] <= delay_value;
				end
			end
		end
	endgenerate

	genvar t;
	generate
		for (t = 0; t < ADDON_N; t++) begin : g_thresh
			always_ff @(posedge clock) begin
				if (reset) begin
					act_thresh[t] <= ACT_THRESH_RESET;
					rel_thresh[t] <= REL_THRESH_RESET;
				end else if (clock_enable && ack && bus_req.write && bank == BANK_THRESH
				             && 32'(index) == t) begin
					act_thresh[t] <= bus_req.writedata[THRESH_ACT_LSB +: VOLT_W];
					rel_thresh[t] <= bus_req.writedata[THRESH_REL_LSB +: VOLT_W];
				end
			end
		end
	endgenerate

	// ==========================================================
	// read data and answer, one wait cycle per access
	always_ff @(posedge clock) begin
		if (reset)
			ack <= 1'b0;
		else if (clock_enable)
			ack <= access;
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			readdata <= '0;
		end else if (clock_enable && access && bus_req.read) begin
			readdata <= '0;
			case (bank)
				BANK_ACT: begin
					if (32'(index) < CH_N)
						readdata <= 32'(act_delay[index]);
				end
				BANK_DROP: begin
					if (32'(index) < CH_N)
						readdata <= 32'(drop_delay[index]);
				end
				BANK_THRESH: begin
					if (32'(index) < ADDON_N)
						readdata <= {16'h0000, rel_thresh[index[2:0]], act_thresh[index[2:0]]};
				end
				default: begin
					case (word)
						REG_POLARITY[7:2]:   readdata <= 32'(polarity);
						REG_AC_MODE[7:2]:    readdata <= 32'(ac_mode);
						REG_FILTERED[7:2]:   readdata <= 32'(filtered_state);
						REG_LOGIC[7:2]:      readdata <= 32'(logic_state);
						REG_CONTACTS[7:2]:   readdata <= 32'(output_contact_channels);
						REG_ROUTE[7:2]:      readdata <= 32'(route);
						REG_NUMBERING[7:2]:  readdata <= 32'(PRECEDING_N + 1);
						REG_SCAN_COUNT[7:2]: readdata <= scan_count;
						default:             readdata <= '0;
					endcase
				end
			endcase
		end
	end

endmodule : dinscan_top

// ### shared/dinscan_pkg.sv
// constants and carriers for the binary input scanner
// assumes one 100 MHz clock and an Avalon-MM master on the register side
// How it works
// - every input is sampled once per 5 ms program cycle, so with zero delays a change reaches the filtered state within one cycle.
// - the internal logic and group selection stage takes the filtered state at the next cycle tick, 0 to 5 ms later.
// - output contacts take the logic stage at the cycle tick after that, one more 5 ms cycle.
// - the add-on module adds 8 channels numbered right after the channels of the modules ahead of it.
// - each add-on channel has activation and release voltage thresholds set by software in 1 V steps.
// - each add-on channel holds its own pick-up delay, release delay and open or closed polarity.
// - polarity 0 reports 1 for an energized channel, polarity 1 reports 0 for it.
// - a 0 to 1 change waits the activation delay, set in 1 ms steps up to 1800 s, reset value zero.
// - a 1 to 0 change waits the drop-off delay, set in 1 ms steps, reset value zero.
// - with AC mode on, 30 ms are added to the release so the input rides over AC half-waves.
package dinscan_pkg;

	// ==========================================================
	// timing
	localparam int CLOCK_HZ         = 100_000_000;
	localparam int PROGRAM_CYCLE_US = 5000;
	localparam int CYCLE_CLOCKS     = PROGRAM_CYCLE_US * (CLOCK_HZ / 1_000_000);
	localparam int DELAY_STEP_US    = 1000;
	localparam int MS_CLOCKS        = DELAY_STEP_US * (CLOCK_HZ / 1_000_000);
	localparam int AC_HOLD_MS       = 30;
	localparam int MAX_DELAY_MS     = 1_800_000;
	localparam int DELAY_W          = 21;

	// ==========================================================
	// channel layout
	localparam int BASE_INPUTS      = 3;
	localparam int ADDON_INPUTS     = 8;
	localparam int PRECEDING_INPUTS = 3;
	localparam int CONTACTS         = 5;
	localparam int VOLT_W           = 8;
	localparam int ROUTE_W          = 4;

	// ==========================================================
	// register map, byte addresses
	localparam int              ADDR_W         = 8;
	localparam logic [7:0]      REG_POLARITY   = 8'h00;
	localparam logic [7:0]      REG_AC_MODE    = 8'h04;
	localparam logic [7:0]      REG_FILTERED   = 8'h08;
	localparam logic [7:0]      REG_LOGIC      = 8'h0C;
	localparam logic [7:0]      REG_CONTACTS   = 8'h10;
	localparam logic [7:0]      REG_ROUTE      = 8'h14;
	localparam logic [7:0]      REG_NUMBERING  = 8'h18;
	localparam logic [7:0]      REG_SCAN_COUNT = 8'h1C;
	localparam logic [7:0]      REG_ACT_DELAY  = 8'h40;
	localparam logic [7:0]      REG_DROP_DELAY = 8'h80;
	localparam logic [7:0]      REG_THRESH     = 8'hC0;
	localparam logic [1:0]      BANK_ACT       = 2'h1;
	localparam logic [1:0]      BANK_DROP      = 2'h2;
	localparam logic [1:0]      BANK_THRESH    = 2'h3;
	localparam int              THRESH_ACT_LSB = 0;
	localparam int              THRESH_REL_LSB = 8;
	localparam logic [VOLT_W-1:0] ACT_THRESH_RESET = 8'h58;
	localparam logic [VOLT_W-1:0] REL_THRESH_RESET = 8'h3C;
	localparam logic [DELAY_W-1:0] DELAY_RESET     = 21'h0;
	localparam logic [31:0]     ROUTE_RESET    = 32'h0000_0000;

	// ==========================================================
	// bus carriers
	typedef struct packed {
		logic [ADDR_W-1:0] address;
		logic              read;
		logic              write;
		logic [31:0]       writedata;
	} avmm_req_t;

	typedef struct packed {
		logic [31:0] readdata;
		logic        waitrequest;
	} avmm_rsp_t;

endpackage : dinscan_pkg
